// ===== include/tw_pkg.sv
package tw_pkg;
// Notes on behaviour
// [RQ1] one clock only; timer tick just enables counting, flags, reloads
// [RQ2] control register: channel a mode in bits 7:6, channel b in 5:4
// [RQ3] a nonzero channel mode hands the pin to the compare output; here mode 01 leaves the pin to the port unless tog_ok allows toggling
// [RQ4] the pin driver follows the direction bit only
// [RQ5] non-pwm match: 01 toggles, 10 clears, 11 sets the output
// [RQ6] fast pwm 01 toggles a only in modes 14, 15; else disconnects
// [RQ7] fast pwm 10 clears on match, sets at bottom; 11 the inverse
// [RQ8] fast pwm compare equal to top acts at top instead of match
// [RQ9] dual-slope 01 toggles a only in modes 9, 11; else disconnects
// [RQ10] dual-slope 10 clears on up match, sets on down match; 11 inverse
// [RQ11] waveform mode joins low bits 1:0 with two high bits
// [RQ12] phase correct: fixed or register top, reload top, overflow bottom
// [RQ13] fast pwm: fixed or register top, reload at bottom, overflow at top
// [RQ14] frequency correct: register top, reload and overflow at bottom
// [RQ15] normal and ctc: immediate compare writes, overflow at max
// [RQ16] software never programs reserved mode 13
// [RQ17] dual-slope counts up to top, one tick there, back down to zero
// [RQ18] tick select 0 stops; 1..5 divide clock by 1, 8, 64, 256, 1024
// [RQ19] pwm modes buffer compare writes, load them at the reload point
// [RQ20] control bits 3:2 read zero; everything resets to zero
	localparam int AW = 8;
	localparam logic [7:0] ADDR_CTRL_A = 8'h80;
	localparam logic [7:0] ADDR_CTRL_B = 8'h84;
	localparam logic [7:0] ADDR_COUNT = 8'h88;
	localparam logic [7:0] ADDR_CMP_A = 8'h8c;
	localparam logic [7:0] ADDR_CMP_B = 8'h90;
	localparam logic [7:0] ADDR_CAPT = 8'h94;
	localparam logic [7:0] ADDR_FLAGS = 8'h98;
	localparam logic [7:0] ADDR_DIR = 8'h9c;
	localparam logic [7:0] CTRL_A_WMASK = 8'hf3;
	localparam logic [7:0] CTRL_A_RST = 8'h00;
	localparam logic [4:0] CTRL_B_RST = 5'h00;
	localparam logic [15:0] WORD_RST = 16'h0000;
	localparam logic [2:0] FLAG_RST = 3'h0;
	localparam logic [1:0] DIR_RST = 2'h0;
	localparam int F_OVF = 0;
	localparam int F_MA = 1;
	localparam int F_MB = 2;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [15:0] BOTTOM = 16'h0000;
	localparam logic [15:0] TOP_8 = 16'h00ff;
	localparam logic [15:0] TOP_9 = 16'h01ff;
	localparam logic [15:0] TOP_10 = 16'h03ff;
	localparam logic [15:0] TOP_MAX = 16'hffff;
	localparam logic [3:0] WM_NORMAL = 4'h0;
	localparam logic [3:0] WM_PC8 = 4'h1;
	localparam logic [3:0] WM_PC9 = 4'h2;
	localparam logic [3:0] WM_PC10 = 4'h3;
	localparam logic [3:0] WM_CTC_A = 4'h4;
	localparam logic [3:0] WM_FAST8 = 4'h5;
	localparam logic [3:0] WM_FAST9 = 4'h6;
	localparam logic [3:0] WM_FAST10 = 4'h7;
	localparam logic [3:0] WM_PFC_CAP = 4'h8;
	localparam logic [3:0] WM_PFC_A = 4'h9;
	localparam logic [3:0] WM_PC_CAP = 4'ha;
	localparam logic [3:0] WM_PC_A = 4'hb;
	localparam logic [3:0] WM_CTC_CAP = 4'hc;
	localparam logic [3:0] WM_FAST_CAP = 4'he;
	localparam logic [3:0] WM_FAST_A = 4'hf;
	localparam logic [2:0] CS_STOP = 3'h0;
	localparam logic [2:0] CS_DIV1 = 3'h1;
	localparam logic [2:0] CS_DIV8 = 3'h2;
	localparam logic [2:0] CS_DIV64 = 3'h3;
	localparam logic [2:0] CS_DIV256 = 3'h4;
	localparam logic [2:0] CS_DIV1024 = 3'h5;
	localparam int PS_DIV8 = 8;
	localparam int PS_DIV64 = 64;
	localparam int PS_DIV256 = 256;
	localparam int PS_DIV1024 = 1024;
	typedef enum logic [2:0] {
		cls_normal, cls_ctc, cls_fast, cls_phase, cls_pfc
	} tw_class_t;
	typedef struct packed {
		logic [1:0] out_mode_a;
		logic [1:0] out_mode_b;
		logic [1:0] rsvd;
		logic [1:0] waveform_mode_low;
	} tw_ctrl_a_t;
	typedef struct packed {
		logic [1:0] waveform_mode_high;
		logic [2:0] tick_source_select;
	} tw_ctrl_b_t;
endpackage: tw_pkg

// ===== src/tw_prescaler.sv
`timescale 1ns/1ps
module tw_prescaler #(
	parameter int PS_W = 10
)(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// selection and tick enable
	input wire logic [2:0] tick_source_select,
	output logic timer_tick
);
	logic [PS_W-1:0] ps_q, ps_d, mask;

	// divider parks at zero while stopped so ticks restart aligned
	always_comb
	begin
		ps_d = (tick_source_select == tw_pkg::CS_STOP) ? '0 : ps_q + 1'b1;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			ps_q <= '0;
		else
			ps_q <= ps_d;
	end

	// tick is a one-cycle enable, never a clock
	always_comb
	begin
		mask = '0;
		timer_tick = 1'b0;
		case (tick_source_select)
			tw_pkg::CS_DIV1: timer_tick = 1'b1; // [RQ18]
			tw_pkg::CS_DIV8: mask = PS_W'(tw_pkg::PS_DIV8 - 1);
			tw_pkg::CS_DIV64: mask = PS_W'(tw_pkg::PS_DIV64 - 1);
			tw_pkg::CS_DIV256: mask = PS_W'(tw_pkg::PS_DIV256 - 1);
			tw_pkg::CS_DIV1024: mask = PS_W'(tw_pkg::PS_DIV1024 - 1);
			default: timer_tick = 1'b0; // stop; pin sources not here
		endcase
		if (mask != '0)
			timer_tick = (ps_q & mask) == mask; // [RQ18]
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	stop_no_tick_a: assert property ( // [RQ18]
		tick_source_select == tw_pkg::CS_STOP |-> !timer_tick)
		else $error("tick while stopped");
	div8_gap_a: assert property ( // [RQ18]
		timer_tick && tick_source_select == tw_pkg::CS_DIV8
		&& $stable(tick_source_select) |=> !timer_tick [*7])
		else $error("divide by 8 ticks too close");
endmodule: tw_prescaler

// ===== src/tw_out_unit.sv
`timescale 1ns/1ps
module tw_out_unit (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// timer events
	input wire logic timer_tick,
	input wire logic hit,
	input wire logic wrap,
	input wire logic down,
	input wire logic cmp_is_top,
	// configuration
	input wire tw_pkg::tw_class_t cls,
	input wire logic [1:0] channel_out_mode,
	input wire logic tog_ok,
	// output
	output logic oc,
	output logic conn
);
	logic oc_q, oc_d, match;

	assign match = timer_tick && hit;
	// 01 outside its allowed modes leaves the pin to the port
	assign conn = channel_out_mode[1]
		|| (channel_out_mode[0] && tog_ok); // [RQ3] [RQ6] [RQ9]
	assign oc = oc_q;

	// compare output waveform
	always_comb
	begin
		oc_d = oc_q;
		case (cls)
			tw_pkg::cls_fast:
			begin
				if (channel_out_mode[1])
				begin
					// match at top is moved onto the wrap itself
					if (wrap)
						oc_d = cmp_is_top ? channel_out_mode[0]
							: !channel_out_mode[0]; // [RQ7] [RQ8]
					else if (match && !cmp_is_top)
						oc_d = channel_out_mode[0]; // [RQ7]
				end
				else if (channel_out_mode[0] && tog_ok && match)
					oc_d = !oc_q; // [RQ6]
			end
			tw_pkg::cls_phase, tw_pkg::cls_pfc:
			begin
				if (channel_out_mode[1] && match)
					oc_d = down ^ channel_out_mode[0]; // [RQ10]
				else if (channel_out_mode[0] && tog_ok && match)
					oc_d = !oc_q; // [RQ9]
			end
			default:
			begin
				if (match && channel_out_mode == 2'h1)
					oc_d = !oc_q; // [RQ5]
				else if (match && channel_out_mode[1])
					oc_d = channel_out_mode[0]; // [RQ5]
			end
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			oc_q <= 1'b0;
		else
			oc_q <= oc_d;
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	nonpwm_set_a: assert property ( // [RQ5]
		match && (cls == tw_pkg::cls_normal || cls == tw_pkg::cls_ctc)
		&& channel_out_mode == 2'h3 |=> oc_q)
		else $error("non-pwm set on match missing");
	dual_up_a: assert property ( // [RQ10]
		match && cls == tw_pkg::cls_phase && !down
		&& channel_out_mode == 2'h2 |=> !oc_q)
		else $error("up-count match did not clear");
	tog_off_a: assert property ( // [RQ6]
		channel_out_mode == 2'h1 && !tog_ok |-> !conn)
		else $error("toggle mode should disconnect");
	fast_bot_a: assert property ( // [RQ7]
		cls == tw_pkg::cls_fast && wrap && channel_out_mode == 2'h2
		&& !cmp_is_top |=> oc_q)
		else $error("non-inverting not set at bottom");
	fast_top_a: assert property ( // [RQ8]
		cls == tw_pkg::cls_fast && wrap && channel_out_mode[1]
		&& cmp_is_top |=> oc_q == $past(channel_out_mode[0]))
		else $error("top match action wrong");
endmodule: tw_out_unit

// ===== src/tw_timer16.sv
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module tw_timer16 #(
	parameter int PS_W = 10
)(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write address
	input wire logic [tw_pkg::AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// axi4-lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read address
	input wire logic [tw_pkg::AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// axi4-lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// compare pins, bit 0 channel a, bit 1 channel b
	input wire logic [1:0] port_data,
	output logic [1:0] pin_out,
	output logic [1:0] pin_oe_n,
	// sticky flags: overflow, match a, match b
	output logic [2:0] flags
);
	tw_pkg::tw_ctrl_a_t ctrl_a_q, ctrl_a_d;
	tw_pkg::tw_ctrl_b_t ctrl_b_q, ctrl_b_d;
	tw_pkg::tw_class_t cls;
	logic [15:0] count_q, count_d, capt_q, capt_d, top;
	logic [1:0][15:0] cmp_q, cmp_d, buf_q, buf_d;
	logic [2:0] flag_q, flag_d;
	logic [1:0] dir_q, dir_d, hit, tog_ok, conn, oc;
	logic [1:0][1:0] omode;
	logic down_q, down_d;
	logic [3:0] waveform_mode;
	logic timer_tick, dual, pwm, at_top, at_bot, wrap, reload, ovf_ev;
	logic aw_ok_q, aw_ok_d, w_ok_q, w_ok_d, b_q, b_d, r_q, r_d;
	logic [7:0] awa_q, awa_d, wa, ra;
	logic [31:0] wd_q, wd_d, rd_q, rd_d;
	logic [3:0] ws_q, ws_d;
	logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
	logic wr_do, cnt_wr;

	function automatic logic [15:0] wr16(input logic [15:0] old,
		input logic [31:0] d, input logic [3:0] s);
		wr16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction: wr16

	function automatic logic mapped(input logic [7:0] a);
		mapped = a >= tw_pkg::ADDR_CTRL_A && a <= tw_pkg::ADDR_DIR;
	endfunction: mapped

	// mode decode
	assign waveform_mode = {ctrl_b_q.waveform_mode_high,
		ctrl_a_q.waveform_mode_low}; // [RQ11]
	always_comb
	begin
		case (waveform_mode)
			tw_pkg::WM_PC8, tw_pkg::WM_PC9, tw_pkg::WM_PC10,
			tw_pkg::WM_PC_CAP, tw_pkg::WM_PC_A: cls = tw_pkg::cls_phase;
			tw_pkg::WM_PFC_CAP, tw_pkg::WM_PFC_A: cls = tw_pkg::cls_pfc;
			tw_pkg::WM_FAST8, tw_pkg::WM_FAST9, tw_pkg::WM_FAST10,
			tw_pkg::WM_FAST_CAP, tw_pkg::WM_FAST_A: cls = tw_pkg::cls_fast;
			tw_pkg::WM_CTC_A, tw_pkg::WM_CTC_CAP: cls = tw_pkg::cls_ctc;
			default: cls = tw_pkg::cls_normal; // reserved runs as normal [RQ16]
		endcase
	end

	// top source per mode
	always_comb
	begin
		case (waveform_mode)
			tw_pkg::WM_PC8, tw_pkg::WM_FAST8: top = tw_pkg::TOP_8; // [RQ12] [RQ13]
			tw_pkg::WM_PC9, tw_pkg::WM_FAST9: top = tw_pkg::TOP_9;
			tw_pkg::WM_PC10, tw_pkg::WM_FAST10: top = tw_pkg::TOP_10;
			tw_pkg::WM_CTC_A, tw_pkg::WM_PFC_A, tw_pkg::WM_PC_A,
			tw_pkg::WM_FAST_A: top = cmp_q[0]; // [RQ14] [RQ15]
			tw_pkg::WM_PFC_CAP, tw_pkg::WM_PC_CAP, tw_pkg::WM_CTC_CAP,
			tw_pkg::WM_FAST_CAP: top = capt_q;
			default: top = tw_pkg::TOP_MAX; // [RQ15]
		endcase
	end

	// counter events, all qualified by the tick
	assign dual = cls == tw_pkg::cls_phase || cls == tw_pkg::cls_pfc;
	assign pwm = dual || cls == tw_pkg::cls_fast;
	// ctc passes a lowered top and runs on to max
	assign at_top = (cls == tw_pkg::cls_ctc) ? count_q == top : count_q >= top;
	assign at_bot = count_q == tw_pkg::BOTTOM;
	assign wrap = timer_tick && at_top && !dual; // [RQ1]
	always_comb
	begin
		case (cls)
			tw_pkg::cls_fast: reload = timer_tick && at_top; // [RQ13]
			tw_pkg::cls_phase: reload = timer_tick && at_top && !down_q; // [RQ12]
			tw_pkg::cls_pfc: reload = timer_tick && at_bot && down_q; // [RQ14]
			default: reload = 1'b0;
		endcase
		case (cls)
			tw_pkg::cls_fast: ovf_ev = timer_tick && at_top; // [RQ13]
			tw_pkg::cls_phase, tw_pkg::cls_pfc:
				ovf_ev = timer_tick && at_bot && down_q; // [RQ12] [RQ14]
			default: ovf_ev = timer_tick && count_q == tw_pkg::TOP_MAX; // [RQ15]
		endcase
	end
	assign hit[0] = count_q == cmp_q[0];
	assign hit[1] = count_q == cmp_q[1];
	assign tog_ok[1] = !pwm;
	assign tog_ok[0] = !pwm || waveform_mode == tw_pkg::WM_FAST_CAP
		|| waveform_mode == tw_pkg::WM_FAST_A
		|| waveform_mode == tw_pkg::WM_PFC_A
		|| waveform_mode == tw_pkg::WM_PC_A; // [RQ6] [RQ9]
	assign omode[0] = ctrl_a_q.out_mode_a; // [RQ2]
	assign omode[1] = ctrl_a_q.out_mode_b; // [RQ2]

	// register write decode
	assign wr_do = aw_ok_q && w_ok_q && !b_q;
	assign wa = {awa_q[7:2], 2'h0};
	assign cnt_wr = wr_do && wa == tw_pkg::ADDR_COUNT;

	// timer state and software writes
	always_comb
	begin
		ctrl_a_d = ctrl_a_q;
		ctrl_b_d = ctrl_b_q;
		count_d = count_q;
		down_d = down_q;
		cmp_d = cmp_q;
		buf_d = buf_q;
		capt_d = capt_q;
		flag_d = flag_q;
		dir_d = dir_q;
		if (timer_tick)
		begin
			if (!dual)
				count_d = at_top ? tw_pkg::BOTTOM : count_q + 16'h0001; // [RQ1]
			else if (!down_q)
			begin
				// turning costs one tick at top
				count_d = at_top ? count_q - 16'h0001 : count_q + 16'h0001; // [RQ17]
				down_d = at_top;
			end
			else
			begin
				count_d = at_bot ? count_q + 16'h0001 : count_q - 16'h0001; // [RQ17]
				down_d = !at_bot;
			end
		end
		if (reload)
			cmp_d = buf_q; // [RQ19]
		if (wr_do)
		begin
			case (wa)
				tw_pkg::ADDR_CTRL_A:
					if (ws_q[0])
						ctrl_a_d = wd_q[7:0] & tw_pkg::CTRL_A_WMASK; // [RQ20]
				tw_pkg::ADDR_CTRL_B:
					if (ws_q[0])
						ctrl_b_d = wd_q[4:0];
				tw_pkg::ADDR_COUNT: count_d = wr16(count_q, wd_q, ws_q);
				tw_pkg::ADDR_CMP_A, tw_pkg::ADDR_CMP_B:
				begin
					buf_d[wa == tw_pkg::ADDR_CMP_B] =
						wr16(buf_q[wa == tw_pkg::ADDR_CMP_B], wd_q, ws_q);
					if (!pwm)
						cmp_d[wa == tw_pkg::ADDR_CMP_B] =
							wr16(buf_q[wa == tw_pkg::ADDR_CMP_B], wd_q, ws_q); // [RQ15]
				end
				tw_pkg::ADDR_CAPT: capt_d = wr16(capt_q, wd_q, ws_q);
				tw_pkg::ADDR_FLAGS:
					if (ws_q[0])
						flag_d = flag_q & ~wd_q[2:0];
				tw_pkg::ADDR_DIR:
					if (ws_q[0])
						dir_d = wd_q[1:0];
				default: dir_d = dir_q;
			endcase
		end
		// hardware sets after the clear, so a same-cycle event survives
		if (ovf_ev)
			flag_d[tw_pkg::F_OVF] = 1'b1;
		if (timer_tick && hit[0])
			flag_d[tw_pkg::F_MA] = 1'b1;
		if (timer_tick && hit[1])
			flag_d[tw_pkg::F_MB] = 1'b1;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ctrl_a_q <= tw_pkg::CTRL_A_RST; // [RQ20]
			ctrl_b_q <= tw_pkg::CTRL_B_RST;
			count_q <= tw_pkg::WORD_RST;
			down_q <= 1'b0;
			cmp_q <= '0;
			buf_q <= '0;
			capt_q <= tw_pkg::WORD_RST;
			flag_q <= tw_pkg::FLAG_RST;
			dir_q <= tw_pkg::DIR_RST;
		end
		else
		begin
			ctrl_a_q <= ctrl_a_d;
			ctrl_b_q <= ctrl_b_d;
			count_q <= count_d;
			down_q <= down_d;
			cmp_q <= cmp_d;
			buf_q <= buf_d;
			capt_q <= capt_d;
			flag_q <= flag_d;
			dir_q <= dir_d;
		end
	end

	// axi4-lite slave, one write and one read at a time
	assign s_axi_awready = !aw_ok_q && !b_q;
	assign s_axi_wready = !w_ok_q && !b_q;
	assign s_axi_arready = !r_q;
	assign ra = {s_axi_araddr[7:2], 2'h0};
	always_comb
	begin
		aw_ok_d = aw_ok_q;
		w_ok_d = w_ok_q;
		awa_d = awa_q;
		wd_d = wd_q;
		ws_d = ws_q;
		b_d = b_q;
		bresp_d = bresp_q;
		r_d = r_q;
		rd_d = rd_q;
		rresp_d = rresp_q;
		if (s_axi_awvalid && s_axi_awready)
		begin
			aw_ok_d = 1'b1;
			awa_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			w_ok_d = 1'b1;
			wd_d = s_axi_wdata;
			ws_d = s_axi_wstrb;
		end
		if (wr_do)
		begin
			aw_ok_d = 1'b0;
			w_ok_d = 1'b0;
			b_d = 1'b1;
			bresp_d = mapped(wa) ? tw_pkg::RESP_OKAY : tw_pkg::RESP_SLVERR;
		end
		else if (b_q && s_axi_bready)
			b_d = 1'b0;
		if (s_axi_arvalid && s_axi_arready)
		begin
			r_d = 1'b1;
			rresp_d = mapped(ra) ? tw_pkg::RESP_OKAY : tw_pkg::RESP_SLVERR;
			case (ra)
				tw_pkg::ADDR_CTRL_A: rd_d = {24'h0, ctrl_a_q};
				tw_pkg::ADDR_CTRL_B: rd_d = {27'h0, ctrl_b_q};
				tw_pkg::ADDR_COUNT: rd_d = {16'h0, count_q};
				tw_pkg::ADDR_CMP_A: rd_d = {16'h0, buf_q[0]};
				tw_pkg::ADDR_CMP_B: rd_d = {16'h0, buf_q[1]};
				tw_pkg::ADDR_CAPT: rd_d = {16'h0, capt_q};
				tw_pkg::ADDR_FLAGS: rd_d = {29'h0, flag_q};
				tw_pkg::ADDR_DIR: rd_d = {30'h0, dir_q};
				default: rd_d = 32'h0;
			endcase
		end
		else if (r_q && s_axi_rready)
			r_d = 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_ok_q <= 1'b0;
			w_ok_q <= 1'b0;
			awa_q <= 8'h00;
			wd_q <= 32'h0;
			ws_q <= 4'h0;
			b_q <= 1'b0;
			bresp_q <= tw_pkg::RESP_OKAY;
			r_q <= 1'b0;
			rd_q <= 32'h0;
			rresp_q <= tw_pkg::RESP_OKAY;
		end
		else
		begin
			aw_ok_q <= aw_ok_d;
			w_ok_q <= w_ok_d;
			awa_q <= awa_d;
			wd_q <= wd_d;
			ws_q <= ws_d;
			b_q <= b_d;
			bresp_q <= bresp_d;
			r_q <= r_d;
			rd_q <= rd_d;
			rresp_q <= rresp_d;
		end
	end
	assign s_axi_bvalid = b_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_rvalid = r_q;
	assign s_axi_rdata = rd_q;
	assign s_axi_rresp = rresp_q;

	tw_prescaler #(.PS_W(PS_W)) u_pre (
		.aclk(aclk),
		.aresetn(aresetn),
		.tick_source_select(ctrl_b_q.tick_source_select),
		.timer_tick(timer_tick)
	);

	// one compare output unit per channel
	for (genvar g = 0; g < 2; g++)
	begin: g_ch
		tw_out_unit u_out (
			.aclk(aclk),
			.aresetn(aresetn),
			.timer_tick(timer_tick),
			.hit(hit[g]),
			.wrap(wrap),
			.down(down_q),
			.cmp_is_top(cmp_q[g] == top),
			.cls(cls),
			.channel_out_mode(omode[g]),
			.tog_ok(tog_ok[g]),
			.oc(oc[g]),
			.conn(conn[g])
		);
		assign pin_out[g] = conn[g] ? oc[g] : port_data[g]; // [RQ3]
	end

	// driver enable follows direction even when compare owns the pin
	assign pin_oe_n = ~dir_q; // [RQ4]
	assign flags = flag_q;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	ctrl_rsvd_a: assert property (ctrl_a_q.rsvd == 2'h0) // [RQ20]
		else $error("reserved control bits set");
	stop_hold_a: assert property ( // [RQ18]
		ctrl_b_q.tick_source_select == tw_pkg::CS_STOP && !cnt_wr
		|=> $stable(count_q))
		else $error("counter moved while stopped");
	dual_turn_a: assert property ( // [RQ17]
		timer_tick && dual && !down_q && count_q == top && !cnt_wr
		|=> down_q && count_q == $past(count_q) - 16'h0001)
		else $error("dual-slope turn at top wrong");
	fast_wrap_a: assert property ( // [RQ13]
		timer_tick && cls == tw_pkg::cls_fast && count_q == top
		&& !cnt_wr |=> count_q == tw_pkg::BOTTOM && flag_q[tw_pkg::F_OVF])
		else $error("fast wrap or overflow missing");
	pfc_bottom_a: assert property ( // [RQ14]
		timer_tick && cls == tw_pkg::cls_pfc && at_bot && down_q
		|=> flag_q[tw_pkg::F_OVF] && cmp_q == $past(buf_q))
		else $error("bottom reload or overflow missing");
	pc_top_a: assert property ( // [RQ12]
		timer_tick && cls == tw_pkg::cls_phase && !down_q
		&& count_q == top |=> cmp_q == $past(buf_q))
		else $error("phase correct reload at top missing");
	buf_hold_a: assert property ( // [RQ19]
		pwm && !reload |=> $stable(cmp_q))
		else $error("active compare changed off reload");
	imm_write_a: assert property ( // [RQ15]
		!pwm && wr_do && wa == tw_pkg::ADDR_CMP_A && ws_q == 4'hf
		|=> cmp_q[0] == $past(wd_q[15:0]))
		else $error("immediate compare write lost");
	pin_own_a: assert property ( // [RQ3]
		(!ctrl_a_q.out_mode_a[1] || pin_out[0] == oc[0])
		&& (!ctrl_a_q.out_mode_b[1] || pin_out[1] == oc[1]))
		else $error("compare output not on pin");
	dir_off_a: assert property ( // [RQ4]
		!dir_q[1] |-> pin_oe_n[1] && (conn[1] || pin_out[1] == port_data[1]))
		else $error("driver enabled without direction");
	fast_wrap_c: cover property (wrap && cls == tw_pkg::cls_fast);
	dual_turn_c: cover property (timer_tick && dual && at_top && !down_q);
	reload_c: cover property (reload && buf_q != cmp_q);
	axi_write_c: cover property (wr_do ##[1:4] s_axi_bvalid && s_axi_bready);
endmodule: tw_timer16

// ===== verif/tw_pin_load.sv
`timescale 1ns/1ps
// board load on the compare pins, with a pull-up on each line
module tw_pin_load (
	// pins from the timer
	input wire logic [1:0] pin_out,
	input wire logic [1:0] pin_oe_n,
	// resolved line level
	output logic [1:0] line
);
	// a released pin floats high, never back to its last value
	assign line = pin_out | pin_oe_n;
endmodule: tw_pin_load

// ===== verif/test_timer16_waveform_mode_control.sv
`timescale 1ns/1ps
module test_timer16_waveform_mode_control;
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'h0;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, pin_out, pin_oe_n, line;
	logic [1:0] port_data = 2'h2;
	logic [2:0] flags;
	logic [1:0] p3, p0;
	int n_fail = 0, checks_done = 0, hi, i;
	// {waveform mode, 2'h0, pins that keep port behaviour} with mode 01
	// on both channels; reserved mode 13 is never programmed
	logic [7:0] rows[15] = '{8'h00, 8'h13, 8'h23, 8'h33, 8'h40, 8'h53,
		8'h63, 8'h73, 8'h83, 8'h92, 8'ha3, 8'hb2, 8'hc0, 8'he2, 8'hf2};
	// {channel a output mode, expected pin after a match}
	logic [2:0] nrm[4] = '{3'h3, 3'h4, 3'h7, 3'h2};

	tw_timer16 u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .port_data, .pin_out,
		.pin_oe_n, .flags);
	tw_pin_load u_load (.pin_out, .pin_oe_n, .line);

	// free-running 20 MHz clock
	initial
		forever #25 aclk = ~aclk;

	task report_and_stop();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask: report_and_stop

	task cmp_word(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e)
		begin
			n_fail++;
			$display("Error at %0t got %h expected %h", $time, g, e);
		end
	endtask: cmp_word

	// a stuck handshake counts as a mismatch and ends the run
	task stuck();
		n_fail++;
		report_and_stop();
	endtask: stuck

	// ready is looked at on the falling edge, where it is settled
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		int n;
		logic ah, wh, bh;
		logic [1:0] r;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hf;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		for (n = 0; n < 40; n++)
		begin
			@(negedge aclk);
			ah = s_axi_awvalid && s_axi_awready;
			wh = s_axi_wvalid && s_axi_wready;
			bh = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge aclk);
			if (ah)
				s_axi_awvalid <= 1'h0;
			if (wh)
				s_axi_wvalid <= 1'h0;
			if (bh)
			begin
				s_axi_bready <= 1'h0;
				break;
			end
		end
		if (n == 40)
			stuck();
		else
			cmp_word({30'h0, r}, {30'h0, er});
	endtask: wr

	task automatic rd(input logic [7:0] a, input logic [31:0] ed,
		input logic [1:0] er);
		int n;
		logic rh, ar;
		logic [31:0] d;
		logic [1:0] r;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		for (n = 0; n < 40; n++)
		begin
			@(negedge aclk);
			ar = s_axi_arvalid && s_axi_arready;
			rh = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge aclk);
			if (ar)
				s_axi_arvalid <= 1'h0;
			if (rh)
			begin
				s_axi_rready <= 1'h0;
				break;
			end
		end
		if (n == 40)
			stuck();
		else
		begin
			cmp_word(d, ed);
			cmp_word({30'h0, r}, {30'h0, er});
		end
	endtask: rd

	// counts cycles with line a high over a window
	task automatic count_hi(input int n, output int c);
		c = 0;
		repeat (n)
		begin
			@(negedge aclk);
			c += line[0];
		end
	endtask: count_hi

	// main sequence
	initial
	begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'h1;
		@(negedge aclk);
		cmp_word({30'h0, pin_oe_n}, 32'h3);
		cmp_word({30'h0, pin_out}, 32'h2);
		rd(8'h80, 32'h0, 2'h0);
		rd(8'h84, 32'h0, 2'h0);
		wr(8'h80, 32'hff, 2'h0);
		rd(8'h80, 32'hf3, 2'h0);
		wr(8'ha0, 32'h1, 2'h2);
		rd(8'ha0, 32'h0, 2'h2);
		wr(8'h9c, 32'h3, 2'h0);
		@(negedge aclk);
		cmp_word({30'h0, pin_oe_n}, 32'h0);
		// a connected pin ignores port_data, a free one follows it
		for (i = 0; i < 15; i++)
		begin
			wr(8'h80, {24'h0, 6'h14, rows[i][5:4]}, 2'h0);
			wr(8'h84, {27'h0, rows[i][7:6], 3'h0}, 2'h0);
			@(posedge aclk) port_data <= 2'h3;
			@(negedge aclk) p3 = line;
			@(posedge aclk) port_data <= 2'h0;
			@(negedge aclk) p0 = line;
			cmp_word({30'h0, p3 & ~p0}, {30'h0, rows[i][1:0]});
		end
		wr(8'h80, 32'h0, 2'h0);
		wr(8'h8c, 32'h5, 2'h0);
		wr(8'h84, 32'h1, 2'h0);
		for (i = 0; i < 4; i++)
		begin
			// restart the count first so only one match meets the new mode
			wr(8'h88, 32'h0, 2'h0);
			wr(8'h80, {24'h0, nrm[i][2:1], 6'h0}, 2'h0);
			repeat (12) @(posedge aclk);
			@(negedge aclk);
			cmp_word({31'h0, line[0]}, {31'h0, nrm[i][0]});
		end
		wr(8'h84, 32'h0, 2'h0);
		wr(8'h88, 32'h1234, 2'h0);
		repeat (20) @(posedge aclk);
		rd(8'h88, 32'h1234, 2'h0);
		// fast pwm 8-bit, compare 0x10: high for counts 0..0x10
		wr(8'h8c, 32'h10, 2'h0);
		wr(8'h80, 32'h81, 2'h0);
		wr(8'h84, 32'h9, 2'h0);
		repeat (300) @(posedge aclk);
		wr(8'h98, 32'h7, 2'h0);
		count_hi(512, hi);
		cmp_word(32'(hi), 32'd34);
		cmp_word({29'h0, flags}, 32'h7);
		wr(8'h80, 32'hc1, 2'h0);
		repeat (300) @(posedge aclk);
		count_hi(512, hi);
		cmp_word(32'(hi), 32'd478);
		// phase correct 8-bit: period of 510 cycles
		wr(8'h84, 32'h0, 2'h0);
		wr(8'h80, 32'h81, 2'h0);
		wr(8'h88, 32'h0, 2'h0);
		wr(8'h84, 32'h1, 2'h0);
		repeat (600) @(posedge aclk);
		count_hi(1020, hi);
		cmp_word(32'(hi), 32'd64);
		wr(8'h80, 32'hc1, 2'h0);
		repeat (600) @(posedge aclk);
		count_hi(1020, hi);
		cmp_word(32'(hi), 32'd956);
		// freq correct, top from capture 0xff: same wave, bottom reload
		wr(8'h94, 32'hff, 2'h0);
		wr(8'h80, 32'h80, 2'h0);
		wr(8'h84, 32'h11, 2'h0);
		repeat (600) @(posedge aclk);
		count_hi(1020, hi);
		cmp_word(32'(hi), 32'd64);
		// fast pwm, top from compare a: match at top acts at top only
		wr(8'h80, 32'h83, 2'h0);
		wr(8'h84, 32'h19, 2'h0);
		repeat (40) @(posedge aclk);
		count_hi(64, hi);
		cmp_word(32'(hi), 32'd0);
		wr(8'h80, 32'h43, 2'h0);
		count_hi(68, hi);
		cmp_word(32'(hi), 32'd34);
		report_and_stop();
	end
endmodule: test_timer16_waveform_mode_control
